// >>> src/vmsel_consts.svh
// constants for the virtual machine select multiplexer
`ifndef VMSEL_CONSTS_SVH
`define VMSEL_CONSTS_SVH

// framing start byte and select keyword
`define VMSEL_STX         8'h02
`define VMSEL_KEYWORD     8'h70
// largest payload that one block may carry (select, machine, command)
`define VMSEL_MAX_PAYLOAD 8'h03
// payload lengths of the three outbound block kinds
`define VMSEL_LEN_CMD     2'h1
`define VMSEL_LEN_SELECT  2'h2
`define VMSEL_LEN_HYBRID  2'h3
// bytes around the payload: start, byte count, block check
`define VMSEL_FRAME_EXTRA 3'h3
// selection the logical switch takes on a service level reset
`define VMSEL_DEFAULT_VM  8'h00

`endif

// >>> src/vmsel_pkg.sv
// types shared by the virtual machine select multiplexer
package vmsel_pkg;

  // outbound sequencer, gray coded along idle-wait-send-wait2
  typedef enum logic [1:0] {
    TX_IDLE        = 2'h0,
    TX_WAIT_GRANT  = 2'h1,
    TX_SEND        = 2'h3,
    TX_WAIT_SECOND = 2'h2
  } tx_state_type;

  // inbound block parser, gray coded along hunt-count-data-check
  typedef enum logic [1:0] {
    RX_HUNT  = 2'h0,
    RX_COUNT = 2'h1,
    RX_DATA  = 2'h3,
    RX_CHECK = 2'h2
  } rx_state_type;

endpackage

// >>> src/block_receiver.sv
// inbound framed block parser: start, byte count, payload, block check
`timescale 1ns/100ps
`include "vmsel_consts.svh"

module block_receiver (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  // received byte stream
  input  wire logic             i_rx_valid,
  input  wire logic [7:0]       i_rx_data,
  input  wire logic             i_abort,
  // parsed block
  output logic                  o_good,
  output logic                  o_bad,
  output logic [1:0]            o_count,
  output logic [2:0][7:0]       o_payload
);

  // all parser state in one word
  typedef struct packed {
    vmsel_pkg::rx_state_type st;
    logic [1:0]              cnt;   // payload length
    logic [1:0]              idx;   // next payload slot
    logic [7:0]              chk;   // running block check
    logic [2:0][7:0]         pay;   // payload bytes
    logic                    good;  // one-cycle good block pulse
    logic                    bad;   // one-cycle bad block pulse
  } rx_reg_type;

  rx_reg_type r;       // registered state
  rx_reg_type next_r;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // next state: block check is xor of byte count and payload
  always_comb begin
    next_r      = r;
    next_r.good = 1'b0;
    next_r.bad  = 1'b0;
    if (i_abort) begin
      // a break or a service level reset drops any half block
      next_r.st = vmsel_pkg::RX_HUNT;
    end else if (i_rx_valid) begin
      case (r.st)
        vmsel_pkg::RX_HUNT: begin
          // bytes outside a block are ignored
          if (i_rx_data == `VMSEL_STX) begin
            next_r.st  = vmsel_pkg::RX_COUNT;
            next_r.idx = 2'h0;
          end
        end
        vmsel_pkg::RX_COUNT: begin
          // lengths the switch cannot hold are refused at once
          if (i_rx_data == 8'h00 || i_rx_data > `VMSEL_MAX_PAYLOAD) begin
            next_r.bad = 1'b1;
            next_r.st  = vmsel_pkg::RX_HUNT;
          end else begin
            next_r.cnt = i_rx_data[1:0];
            next_r.chk = i_rx_data;
            next_r.st  = vmsel_pkg::RX_DATA;
          end
        end
        vmsel_pkg::RX_DATA: begin
          next_r.pay[r.idx] = i_rx_data;
          next_r.chk        = r.chk ^ i_rx_data;
          next_r.idx        = r.idx + 2'h1;
          if (r.idx + 2'h1 == r.cnt) begin
            next_r.st = vmsel_pkg::RX_CHECK;
          end
        end
        vmsel_pkg::RX_CHECK: begin
          next_r.good = (i_rx_data == r.chk);
          next_r.bad  = (i_rx_data != r.chk);
          next_r.st   = vmsel_pkg::RX_HUNT;
        end
        default: begin
          next_r.st = vmsel_pkg::RX_HUNT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state word
  assign o_good    = r.good;
  assign o_bad     = r.bad;
  assign o_count   = r.cnt;
  assign o_payload = r.pay;

endmodule

// >>> src/vm_select_mux.sv
// tributary message handling for several virtual machines on one address
`timescale 1ns/100ps
`include "vmsel_consts.svh"

// Summary of operation
// - machine command raises the service request flag
// - new machine: send select block on grant
// - second grant sends the command block
// - acknowledge good block, deliver to selection
// - select and command may share one block
// - received select acknowledged and sets switch
// - selection holds until the next select or service reset
// - same machine: omit the select exchange
// - service reset: machine zero, errors cleared, unless a select, a grant or an error in that same cycle sets them
module vm_select_mux #(
  parameter int VM_W = 4  // bits of a virtual machine number, at most 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  // commands from the attached virtual machines
  input  wire logic             i_cmd_valid,
  input  wire logic [VM_W-1:0]  i_cmd_vm,
  input  wire logic [7:0]       i_cmd_data,
  input  wire logic             i_combine,
  output logic                  o_cmd_ready,
  // outbound link
  input  wire logic             i_grant,
  input  wire logic             i_tx_ready,
  output logic                  o_service_request,
  output logic                  o_tx_valid,
  output logic [7:0]            o_tx_data,
  // inbound link
  input  wire logic             i_rx_valid,
  input  wire logic [7:0]       i_rx_data,
  input  wire logic             i_rx_break,
  output logic                  o_ack,
  output logic                  o_nak,
  // delivery to the virtual machines
  output logic                  o_deliver_valid,
  output logic [VM_W-1:0]       o_deliver_vm,
  output logic [7:0]            o_deliver_data,
  // service level control and status
  input  wire logic             i_ssl_reset,
  output logic [VM_W-1:0]       o_selected_vm,
  output logic                  o_error
);

  // all block state in one word
  typedef struct packed {
    vmsel_pkg::tx_state_type st;
    logic [5:0][7:0]         frm;     // outbound block being sent
    logic [2:0]              len;     // bytes in that block
    logic [2:0]              idx;     // byte now offered
    logic                    second;  // command block still owed
    logic [7:0]              cmd;     // pending command
    logic [VM_W-1:0]         cvm;     // its source machine
    logic [VM_W-1:0]         tx_sel;  // selection last sent upstream
    logic [VM_W-1:0]         rx_sel;  // logical switch for inbound
    logic                    service_request_flag;     // service request flag
    logic                    ready;   // command accepted next cycle
    logic                    tx_valid;
    logic [7:0]              tx_data;
    logic                    ack;
    logic                    nak;
    logic                    dv;      // delivery pulse
    logic [VM_W-1:0]         dvm;
    logic [7:0]              ddata;
    logic                    err;     // sticky error flag
  } mux_reg_type;
  mux_reg_type      r;           // registered state
  mux_reg_type      next_r;      // next state
  logic             rx_good;     // parser: good block pulse
  logic             rx_bad;      // parser: bad block pulse
  logic [1:0]       rx_count;    // parser: payload length
  logic [2:0][7:0]  rx_payload;  // parser: payload bytes
  logic             rx_is_sel;   // good block opens with a select
  logic [VM_W-1:0]  rx_sel_vm;   // machine named by that select

  assign rx_is_sel = (rx_payload[0] == `VMSEL_KEYWORD) && (rx_count >= 2'h2);
  assign rx_sel_vm = rx_payload[1][VM_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // inbound parser; a break resynchronises it
  block_receiver u_rx (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_rx_valid (i_rx_valid),
    .i_rx_data  (i_rx_data),
    .i_abort    (i_rx_break || i_ssl_reset),
    .o_good     (rx_good),
    .o_bad      (rx_bad),
    .o_count    (rx_count),
    .o_payload  (rx_payload)
  );
  // builds a block from its payload; the check covers count and payload
  function automatic logic [5:0][7:0] make_frame(
    input logic [1:0]      pn,
    input logic [2:0][7:0] pl
  );
    logic [5:0][7:0] f;
    logic [7:0]      bck;
    f      = '0;
    bck    = {6'h00, pn};
    f[0]   = `VMSEL_STX;
    f[1]   = {6'h00, pn};
    for (int k = 0; k < 3; k++) begin
      if (k < int'(pn)) begin
        f[k + 2] = pl[k];
        bck      = bck ^ pl[k];
      end
    end
    f[int'(pn) + 2] = bck;
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [2:0][7:0] pl;
    logic [1:0]      pn;
    logic            send;
    pl             = '0;
    pn             = `VMSEL_LEN_CMD;
    send           = 1'b0;
    next_r         = r;
    next_r.ack     = 1'b0;
    next_r.nak     = 1'b0;
    next_r.dv      = 1'b0;
    // service level reset; later events this cycle still win
    if (i_ssl_reset) begin
      next_r.rx_sel = VM_W'(`VMSEL_DEFAULT_VM);
      next_r.tx_sel = VM_W'(`VMSEL_DEFAULT_VM);
      next_r.err    = 1'b0;
    end
    // outbound sequencer
    case (r.st)
      vmsel_pkg::TX_IDLE: begin
        if (i_cmd_valid && r.ready) begin
          next_r.cmd = i_cmd_data;
          next_r.cvm = i_cmd_vm;
          next_r.service_request_flag = 1'b1;
          next_r.st  = vmsel_pkg::TX_WAIT_GRANT;
        end
      end
      vmsel_pkg::TX_WAIT_GRANT: begin
        if (i_grant) begin
          send  = 1'b1;
          pl[0] = r.cmd;
          if (r.cvm != r.tx_sel) begin
            // switch upstream first: select block, or hybrid when allowed
            pl[0]         = `VMSEL_KEYWORD;
            pl[1]         = 8'(r.cvm);
            pl[2]         = r.cmd;
            pn            = i_combine ? `VMSEL_LEN_HYBRID
                                      : `VMSEL_LEN_SELECT;
            next_r.second = !i_combine;
            next_r.tx_sel = r.cvm;
          end else begin
            // same machine as before: command alone
            next_r.second = 1'b0;
          end
          // request stays up while a second block is still owed
          next_r.service_request_flag = next_r.second;
        end
      end
      vmsel_pkg::TX_SEND: begin
        if (r.tx_valid && i_tx_ready) begin
          if (r.idx + 3'h1 == r.len) begin
            next_r.tx_valid = 1'b0;
            next_r.st       = r.second ? vmsel_pkg::TX_WAIT_SECOND
                                       : vmsel_pkg::TX_IDLE;
          end else begin
            next_r.idx     = r.idx + 3'h1;
            next_r.tx_data = r.frm[r.idx + 3'h1];
          end
        end
      end
      vmsel_pkg::TX_WAIT_SECOND: begin
        // the acknowledge is not needed; the next grant is the cue
        if (i_grant) begin
          send          = 1'b1;
          pl[0]         = r.cmd;
          next_r.second = 1'b0;
          next_r.service_request_flag    = 1'b0;
        end
      end
      default: begin
        next_r.st = vmsel_pkg::TX_IDLE;
      end
    endcase
    // load a fresh block and offer its first byte
    if (send) begin
      next_r.frm      = make_frame(pn, pl);
      next_r.len      = {1'b0, pn} + `VMSEL_FRAME_EXTRA;
      next_r.idx      = 3'h0;
      next_r.tx_valid = 1'b1;
      next_r.tx_data  = `VMSEL_STX;
      next_r.st       = vmsel_pkg::TX_SEND;
    end
    next_r.ready = (next_r.st == vmsel_pkg::TX_IDLE);
    // inbound blocks
    if (rx_good) begin
      next_r.ack = 1'b1;
      if (rx_is_sel) begin
        next_r.rx_sel = rx_sel_vm;
        if (rx_count == `VMSEL_LEN_HYBRID) begin
          next_r.dv    = 1'b1;
          next_r.dvm   = rx_sel_vm;
          next_r.ddata = rx_payload[2];
        end
      end else if (rx_count == `VMSEL_LEN_CMD) begin
        next_r.dv    = 1'b1;
        next_r.dvm   = r.rx_sel;
        next_r.ddata = rx_payload[0];
      end else begin
        // longer block without a select is not understood
        next_r.err = 1'b1;
      end
    end
    if (rx_bad) begin
      next_r.nak = 1'b1;
      next_r.err = 1'b1;  // set beats a reset in the same cycle
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  // outputs straight from the state word
  assign o_cmd_ready       = r.ready;
  assign o_service_request = r.service_request_flag;
  assign o_tx_valid        = r.tx_valid;
  assign o_tx_data         = r.tx_data;
  assign o_ack             = r.ack;
  assign o_nak             = r.nak;
  assign o_deliver_valid   = r.dv;
  assign o_deliver_vm      = r.dvm;
  assign o_deliver_data    = r.ddata;
  assign o_selected_vm     = r.rx_sel;
  assign o_error           = r.err;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence grant_new_vm;
    r.st == vmsel_pkg::TX_WAIT_GRANT && i_grant && r.cvm != r.tx_sel;
  endsequence
  sequence grant_same_vm;
    r.st == vmsel_pkg::TX_WAIT_GRANT && i_grant && r.cvm == r.tx_sel;
  endsequence
  svc_raise_a: assert property (
    i_cmd_valid && o_cmd_ready |=> o_service_request ##1 !o_cmd_ready)
    else $error("service request not raised on accepted command");
  select_first_a: assert property (
    grant_new_vm and !i_combine |=> r.len == 3'h5
      && r.frm[2] == `VMSEL_KEYWORD && r.second && o_tx_data == `VMSEL_STX)
    else $error("select block not sent for new machine");
  second_block_a: assert property (
    r.st == vmsel_pkg::TX_WAIT_SECOND && i_grant |=> r.len == 3'h4
      && r.frm[2] == r.cmd && !o_service_request)
    else $error("command block not sent on second grant");
  hybrid_frame_a: assert property (
    grant_new_vm and i_combine |=> r.len == 3'h6 && !r.second
      && r.frm[4] == r.cmd)
    else $error("hybrid block malformed");
  same_vm_a: assert property (
    grant_same_vm |=> r.len == 3'h4 && r.frm[2] == r.cmd)
    else $error("select sent for unchanged machine");
  deliver_sel_a: assert property (
    rx_good && !rx_is_sel && rx_count == 2'h1 |=> o_ack && o_deliver_valid
      && o_deliver_vm == $past(o_selected_vm))
    else $error("command not delivered to selected machine");
  switch_set_a: assert property (
    rx_good && rx_is_sel |=> o_ack && o_selected_vm == $past(rx_sel_vm))
    else $error("select did not set the switch");
  select_holds_a: assert property (
    !(rx_good && rx_is_sel) && !i_ssl_reset |=> $stable(o_selected_vm))
    else $error("selection changed without a select");
  ssl_reset_a: assert property (
    i_ssl_reset && !rx_good && !rx_bad |=> o_selected_vm == '0 && !o_error)
    else $error("service reset did not restore defaults");
endmodule

// >>> bench/ctrl_model.sv
// bus controller model: polls, grants and takes outbound bytes
`timescale 1ns/100ps

module ctrl_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // link from the tributary
  input  wire logic       i_service_request,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  // pacing chosen by the bench
  input  wire logic       i_slow,
  // grant and byte acceptance
  output logic            o_grant,
  output logic            o_tx_ready
);
  logic [7:0] seen[$];  // bytes taken, emptied by the bench
  logic       pend;     // grant given, block not yet over
  logic       saw;      // block of the last grant has started

  //////////////////////////////////////////////////////////////////////
  // poll: a raised request earns a grant; a request still standing
  // after a select block earns the second grant
  always @(negedge i_clk) begin
    o_grant <= 1'b0;
    // slow mode stalls every other cycle to test byte holding
    o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
    if (!i_resetn) begin
      pend <= 1'b0;
      saw <= 1'b0;
    end else if (pend) begin
      // wait for the granted block to start and end
      if (i_tx_valid)
        saw <= 1'b1;
      else if (saw) begin
        pend <= 1'b0;
        saw <= 1'b0;
      end
    end else if (i_service_request && !i_tx_valid) begin
      o_grant <= 1'b1;
      pend <= 1'b1;
    end
  end

  // take a byte at each edge where both sides agree
  always @(posedge i_clk)
    if (i_resetn && i_tx_valid && o_tx_ready)
      seen.push_back(i_tx_data);
endmodule

// >>> bench/tb.sv
// self-checking bench for the virtual machine select multiplexer
`timescale 1ns/100ps

module tb;
  logic       i_clk, i_resetn, i_cmd_valid, i_combine, i_grant;
  logic       i_tx_ready, i_rx_valid, i_rx_break, i_ssl_reset, slow;
  logic [3:0] i_cmd_vm, o_deliver_vm, o_selected_vm, tx_sel, rx_sel;
  logic [7:0] i_cmd_data, i_rx_data, o_tx_data, o_deliver_data;
  logic       o_cmd_ready, o_service_request, o_tx_valid, o_ack, o_nak;
  logic       o_deliver_valid, o_error;
  logic [7:0] p[$];      // inbound payload under construction
  int         mismatches, checks_done, cycles;

  // one case: outbound command or inbound block
  typedef struct packed {
    logic       out;   // 1: outbound command, 0: inbound block
    logic [3:0] vm;    // machine number
    logic [7:0] cmd;   // command byte
    logic [1:0] mode;  // combine flag, or inbound payload length
    logic       slow;  // controller stalls every other cycle
  } row_type;
  row_type    r;
  row_type    rows [9] = '{
    '{1'h1, 4'h3, 8'hA5, 2'h0, 1'h0}, '{1'h1, 4'h3, 8'h5A, 2'h0, 1'h1},
    '{1'h1, 4'h7, 8'hC3, 2'h1, 1'h0}, '{1'h1, 4'h0, 8'h11, 2'h0, 1'h1},
    '{1'h1, 4'h0, 8'hFF, 2'h1, 1'h0}, '{1'h0, 4'h0, 8'h44, 2'h1, 1'h0},
    '{1'h0, 4'h5, 8'h00, 2'h2, 1'h0}, '{1'h0, 4'h0, 8'h66, 2'h1, 1'h0},
    '{1'h0, 4'h9, 8'h77, 2'h3, 1'h0}};

  vm_select_mux #(.VM_W(4)) u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
    .i_cmd_vm(i_cmd_vm), .i_cmd_data(i_cmd_data), .i_combine(i_combine),
    .o_cmd_ready(o_cmd_ready), .i_grant(i_grant), .i_tx_ready(i_tx_ready),
    .o_service_request(o_service_request), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
    .i_rx_break(i_rx_break), .o_ack(o_ack), .o_nak(o_nak),
    .o_deliver_valid(o_deliver_valid), .o_deliver_vm(o_deliver_vm),
    .o_deliver_data(o_deliver_data), .i_ssl_reset(i_ssl_reset),
    .o_selected_vm(o_selected_vm), .o_error(o_error));

  ctrl_model u_ctrl (
    .i_clk(i_clk), .i_resetn(i_resetn),
    .i_service_request(o_service_request), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .i_slow(slow), .o_grant(i_grant),
    .o_tx_ready(i_tx_ready));

  //////////////////////////////////////////////////////////////////////
  // clock, and a ceiling far above the few hundred cycles needed
  always #2 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  // offer one command, let the model grant, compare the bytes sent
  task automatic send_cmd(input logic [3:0] vm, input logic [7:0] cmd,
                          input logic comb);
    logic [7:0] e[$];
    logic [7:0] v;
    int         n;
    v = {4'h0, vm};
    if (vm != tx_sel && comb)
      e = '{8'h02, 8'h03, 8'h70, v, cmd, 8'h73 ^ v ^ cmd};
    else begin
      if (vm != tx_sel)
        e = '{8'h02, 8'h02, 8'h70, v, 8'h72 ^ v};
      e = {e, 8'h02, 8'h01, cmd, 8'h01 ^ cmd};
    end
    tx_sel = vm;
    u_ctrl.seen.delete();
    @(negedge i_clk);
    i_cmd_valid = 1'b1;
    i_cmd_vm = vm;
    i_cmd_data = cmd;
    i_combine = comb;
    // ready is read where it is settled; the next rising edge takes it
    n = 0;
    while (o_cmd_ready !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    chk("request", 8'h01, {7'h0, o_service_request});
    chk("ready low", 8'h00, {7'h0, o_cmd_ready});
    n = 0;
    while (o_cmd_ready !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    chk("tx length", 8'(e.size()), 8'(u_ctrl.seen.size()));
    foreach (e[i])
      chk("tx byte", e[i], u_ctrl.seen[i]);
  endtask

  // send start, payload and check as the controller forwards it
  task automatic rx_block(input logic [7:0] b[$], input logic bad);
    logic [7:0] c;
    c = 8'h00;
    foreach (b[i])
      c ^= b[i];
    b = {8'h02, b, c ^ {bad, 7'h0}};
    foreach (b[i]) begin
      @(negedge i_clk);
      i_rx_valid = 1'b1;
      i_rx_data = b[i];
    end
    @(negedge i_clk);
    i_rx_valid = 1'b0;
  endtask

  // answer pulses two cycles after the check byte, then gone
  task automatic rx_expect(input logic [7:0] ack, nak, dv, dat);
    // the parser flags the block at one edge, the answer is registered next
    @(negedge i_clk);
    chk("ack", ack, {7'h0, o_ack});
    chk("nak", nak, {7'h0, o_nak});
    chk("deliver", dv, {7'h0, o_deliver_valid});
    if (dv[0]) begin
      chk("deliver vm", {4'h0, rx_sel}, {4'h0, o_deliver_vm});
      chk("deliver data", dat, o_deliver_data);
    end
    chk("selected", {4'h0, rx_sel}, {4'h0, o_selected_vm});
    @(negedge i_clk);
    chk("ack pulse", 8'h00, {7'h0, o_ack});
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    {i_clk, i_cmd_valid, i_combine, i_rx_valid, i_rx_break} = '0;
    {i_ssl_reset, slow, i_cmd_vm, i_cmd_data, i_rx_data} = '0;
    {tx_sel, rx_sel, mismatches, checks_done, cycles} = '0;
    i_resetn = 1'b0;
    repeat (5) @(negedge i_clk);
    // held in reset: machine zero, nothing pending, nothing offered
    chk("ready first", 8'h00, {7'h0, o_cmd_ready});
    chk("reset request", 8'h00, {7'h0, o_service_request});
    chk("reset select", 8'h00, {4'h0, o_selected_vm});
    chk("reset error", 8'h00, {7'h0, o_error});
    i_resetn = 1'b1;
    // the first edge after release raises ready
    @(negedge i_clk);
    chk("ready second", 8'h01, {7'h0, o_cmd_ready});
    $display("test reset done");
    // ordinary cases from the table
    foreach (rows[k]) begin
      r = rows[k];
      slow = r.slow;
      if (r.out)
        send_cmd(r.vm, r.cmd, r.mode[0]);
      else begin
        if (r.mode == 2'h1)
          p = '{8'h01, r.cmd};
        else if (r.mode == 2'h2)
          p = '{8'h02, 8'h70, {4'h0, r.vm}};
        else
          p = '{8'h03, 8'h70, {4'h0, r.vm}, r.cmd};
        if (r.mode != 2'h1)
          rx_sel = r.vm;
        rx_block(p, 1'b0);
        rx_expect(8'h01, 8'h00, {7'h0, r.mode != 2'h2}, r.cmd);
      end
      $display("test row %0d done", k);
    end
    // counts of zero and above three refused after the count byte
    for (int j = 0; j < 2; j++) begin
      @(negedge i_clk);
      i_rx_valid = 1'b1;
      i_rx_data = 8'h02;
      @(negedge i_clk);
      i_rx_data = j ? 8'h04 : 8'h00;
      @(negedge i_clk);
      i_rx_valid = 1'b0;
      @(negedge i_clk);
      chk("count refused nak", 8'h01, {7'h0, o_nak});
    end
    $display("test zero count done");
    // break drops a half block; the next block still lands
    @(negedge i_clk);
    i_rx_valid = 1'b1;
    i_rx_data = 8'h02;
    @(negedge i_clk);
    i_rx_data = 8'h01;
    @(negedge i_clk);
    i_rx_valid = 1'b0;
    i_rx_break = 1'b1;
    @(negedge i_clk);
    i_rx_break = 1'b0;
    rx_block('{8'h01, 8'h5C}, 1'b0);
    rx_expect(8'h01, 8'h00, 8'h01, 8'h5C);
    $display("test break done");
    // corrupt check: refused, error held until the service reset
    rx_block('{8'h01, 8'h33}, 1'b1);
    rx_expect(8'h00, 8'h01, 8'h00, 8'h33);
    chk("error set", 8'h01, {7'h0, o_error});
    send_cmd(4'h6, 8'h21, 1'b0);
    @(negedge i_clk);
    i_ssl_reset = 1'b1;
    @(negedge i_clk);
    i_ssl_reset = 1'b0;
    {tx_sel, rx_sel} = '0;
    chk("error clear", 8'h00, {7'h0, o_error});
    chk("select zero", 8'h00, {4'h0, o_selected_vm});
    send_cmd(4'h0, 8'h42, 1'b0);
    rx_block('{8'h01, 8'h99}, 1'b0);
    rx_expect(8'h01, 8'h00, 8'h01, 8'h99);
    $display("test service reset done");
    // two bytes without the select keyword: taken, flagged, not delivered
    rx_block('{8'h02, 8'h55, 8'h66}, 1'b0);
    rx_expect(8'h01, 8'h00, 8'h00, 8'h00);
    chk("error on unknown", 8'h01, {7'h0, o_error});
    $display("test unknown block done");
    finish_test();
  end
endmodule
